/* File: asimr_pkg.sv */
package asimr_pkg;

  // Register byte addresses
  localparam logic [31:0] STA_OFS = 32'hFFFF_0500;
  localparam logic [31:0] MSK_OFS = 32'hFFFF_0504;
  localparam logic [31:0] MDE_OFS = 32'hFFFF_0508;
  localparam logic [31:0] FLT_OFS = 32'hFFFF_050C;
  localparam logic [31:0] CTL_OFS = 32'hFFFF_0510;
  localparam logic [31:0] CUR_OFS = 32'hFFFF_0514;
  localparam logic [31:0] VT_OFS = 32'hFFFF_0518;
  localparam logic [31:0] TH_OFS = 32'hFFFF_051C;
  localparam logic [31:0] CFG_OFS = 32'hFFFF_0520;

  // Status bit positions
  localparam int CAL_BIT = 15;
  localparam int VT_ERR_BIT = 13;
  localparam int CUR_ERR_BIT = 12;
  localparam int CONT_BIT = 5;
  localparam int CMP_BIT = 4;
  localparam int TRDY_BIT = 2;
  localparam int VRDY_BIT = 1;
  localparam int CRDY_BIT = 0;

  // Control bit positions
  localparam int MODE_CONT_BIT = 5;
  localparam int CTL_EN_BIT = 15;
  localparam int CFG_CMP_BIT = 0;
  localparam int CFG_VEN_BIT = 1;
  localparam int CFG_TEN_BIT = 2;

  // Reset values
  localparam logic [15:0] STA_RST = 16'h0000;
  localparam logic [7:0] MSK_RST = 8'h00;
  localparam logic [7:0] MDE_RST = 8'h00;
  localparam logic [15:0] FLT_RST = 16'h0000;
  localparam logic [15:0] CTL_RST = 16'h0000;
  localparam logic [15:0] TH_RST = 16'h0000;
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam logic [15:0] DAT_RST = 16'h0000;

  // Saturation codes, two's complement
  localparam logic [15:0] POS_FS = 16'h7FFF;
  localparam logic [15:0] NEG_FS = 16'h8000;

  typedef struct packed {
    logic done;
    logic over;
    logic under;
    logic is_temp;
    logic [15:0] data;
  } asimr_evt_t;

  function automatic logic [15:0] asimr_sat(input asimr_evt_t e);
    asimr_sat = e.over ? POS_FS : (e.under ? NEG_FS : e.data);
  endfunction

  function automatic logic [15:0] asimr_abs(input logic [15:0] v);
    asimr_abs = v[15] ? 16'(~v + 16'h0001) : v;
  endfunction

endpackage

/* File: asimr_regs.sv */
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ns

module asimr_regs
  import asimr_pkg::*;
(
  input wire logic pclk, // System clock
  input wire logic presetn, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [31:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error, unmapped address
  input wire asimr_evt_t cur_evt, // Current conversion event
  input wire asimr_evt_t vt_evt, // Voltage/temperature event
  input wire logic cal_done, // Calibration finished pulse
  input wire logic core_pwr_down, // Core powered down level
  output logic conv_irq, // Combined interrupt
  output logic [7:0] conv_mode, // Mode register contents
  output logic [15:0] conv_filter, // Filter register contents
  output logic [15:0] cur_ctrl, // Current control contents
  output logic [7:0] conv_config // Config register contents
);

  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic irq_q;
  logic [15:0] sta_q;
  logic cal_q;
  logic vt_err_q;
  logic cur_err_q;
  logic cont_q;
  logic cmp_q;
  logic trdy_q;
  logic vrdy_q;
  logic crdy_q;
  logic [7:0] msk_q;
  logic [7:0] msk_d;
  logic [7:0] mde_q;
  logic [7:0] mde_d;
  logic [15:0] flt_q;
  logic [15:0] flt_d;
  logic [15:0] ctl_q;
  logic [15:0] ctl_d;
  logic [15:0] th_q;
  logic [15:0] th_d;
  logic [7:0] cfg_q;
  logic [7:0] cfg_d;
  logic [15:0] cur_dat_q;
  logic [15:0] cur_dat_d;
  logic [15:0] vt_dat_q;
  logic [15:0] vt_dat_d;

  // Bus phase decode
  wire logic setup = psel & ~penable;
  wire logic xfer = psel & penable & pready_q;
  wire logic wr = xfer & pwrite;
  wire logic rd = xfer & ~pwrite;

  wire logic hit_sta = (paddr == STA_OFS);
  wire logic hit_msk = (paddr == MSK_OFS);
  wire logic hit_mde = (paddr == MDE_OFS);
  wire logic hit_flt = (paddr == FLT_OFS);
  wire logic hit_ctl = (paddr == CTL_OFS);
  wire logic hit_cur = (paddr == CUR_OFS);
  wire logic hit_vt = (paddr == VT_OFS);
  wire logic hit_th = (paddr == TH_OFS);
  wire logic hit_cfg = (paddr == CFG_OFS);
  wire logic mapped = hit_sta | hit_msk | hit_mde | hit_flt | hit_ctl
                    | hit_cur | hit_vt | hit_th | hit_cfg;

  wire logic wr_msk = wr & hit_msk;
  wire logic wr_mde = wr & hit_mde;
  wire logic wr_flt = wr & hit_flt;
  wire logic wr_ctl = wr & hit_ctl;
  wire logic wr_th = wr & hit_th;
  wire logic wr_cfg = wr & hit_cfg;
  wire logic rd_cur = rd & hit_cur;
  wire logic rd_vt = rd & hit_vt;

  // Clearing strobes
  wire logic cal_clr = wr_mde | wr_flt | wr_ctl;
  wire logic reconfig = wr_mde | wr_flt | wr_ctl | wr_cfg;

  // Channel enables
  wire logic cur_en = ctl_q[CTL_EN_BIT];
  wire logic volt_en = cfg_q[CFG_VEN_BIT];
  wire logic temp_en = cfg_q[CFG_TEN_BIT];
  wire logic cmp_en = cfg_q[CFG_CMP_BIT];

  // Current conversion handling
  wire logic cur_bad = cur_evt.over | cur_evt.under;
  wire logic [15:0] cur_val = asimr_sat(cur_evt);
  // Result held until its ready flag is gone, unless the core sleeps
  wire logic cur_wr = cur_evt.done
                    & (~sta_q[CRDY_BIT] | core_pwr_down);
  wire logic cmp_hit = cur_evt.done & cmp_en
                     & (asimr_abs(cur_val) > th_q);

  // Voltage/temperature conversion handling
  wire logic vt_bad = vt_evt.over | vt_evt.under;
  wire logic [15:0] vt_val = asimr_sat(vt_evt);
  wire logic vt_rdy_now = vt_evt.is_temp ? sta_q[TRDY_BIT] : sta_q[VRDY_BIT];
  wire logic vt_wr = vt_evt.done & (~vt_rdy_now | core_pwr_down);

  // Status set terms; each set wins over a clear in the same cycle
  wire logic cal_set = cal_done;
  wire logic vt_err_set = vt_evt.done & vt_bad;
  wire logic cur_err_set = cur_evt.done & cur_bad;
  wire logic cont_set = cur_evt.done & mde_q[MODE_CONT_BIT];
  wire logic trdy_set = (vt_wr & vt_evt.is_temp & temp_en)
                      | (cal_done & temp_en);
  wire logic vrdy_set = (vt_wr & ~vt_evt.is_temp & volt_en)
                      | (cal_done & volt_en);
  wire logic crdy_set = (cur_wr & cur_en)
                      | (cal_done & cur_en);

  // Status clear terms
  wire logic vt_err_clr = vt_wr & ~vt_bad;
  wire logic cur_err_clr = cur_wr & ~cur_bad;
  wire logic cont_clr = rd_cur;
  wire logic crdy_clr = rd_cur;
  wire logic tv_rdy_clr = rd_cur | rd_vt;

  wire logic cal_d = cal_set | (sta_q[CAL_BIT] & ~cal_clr);
  wire logic vt_err_d = vt_err_set | (sta_q[VT_ERR_BIT] & ~vt_err_clr);
  wire logic cur_err_d = cur_err_set | (sta_q[CUR_ERR_BIT] & ~cur_err_clr);
  wire logic cont_d = cont_set | (sta_q[CONT_BIT] & ~cont_clr);
  wire logic cmp_d = cmp_hit | (sta_q[CMP_BIT] & ~reconfig);
  wire logic trdy_d = trdy_set | (sta_q[TRDY_BIT] & ~tv_rdy_clr);
  wire logic vrdy_d = vrdy_set | (sta_q[VRDY_BIT] & ~tv_rdy_clr);
  wire logic crdy_d = crdy_set | (sta_q[CRDY_BIT] & ~crdy_clr);

  // Unused positions stay zero; no bus write reaches this vector
  assign sta_q = {cal_q, 1'b0, vt_err_q, cur_err_q, 6'h00,
                  cont_q, cmp_q, 1'b0, trdy_q, vrdy_q, crdy_q};

  // Only the lower byte can interrupt
  wire logic irq_d = |(sta_q[7:0] & msk_q);

  // Read multiplexer
  wire logic [15:0] rd_word =
    hit_sta ? sta_q :
    hit_msk ? {8'h00, msk_q} :
    hit_mde ? {8'h00, mde_q} :
    hit_flt ? flt_q :
    hit_ctl ? ctl_q :
    hit_cur ? cur_dat_q :
    hit_vt ? vt_dat_q :
    hit_th ? th_q :
    hit_cfg ? {8'h00, cfg_q} :
    16'h0000;

  // Next values of the software registers
  assign msk_d = wr_msk ? pwdata[7:0] : msk_q;
  assign mde_d = wr_mde ? pwdata[7:0] : mde_q;
  assign flt_d = wr_flt ? pwdata[15:0] : flt_q;
  assign ctl_d = wr_ctl ? pwdata[15:0] : ctl_q;
  assign th_d = wr_th ? pwdata[15:0] : th_q;
  assign cfg_d = wr_cfg ? pwdata[7:0] : cfg_q;
  // Held results keep the unread value for software
  assign cur_dat_d = cur_wr ? cur_val : cur_dat_q;
  assign vt_dat_d = vt_wr ? vt_val : vt_dat_q;

  // Zero wait state: data captured in setup, ready in access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      prdata_q <= setup ? {16'h0000, rd_word} : prdata_q;
      pready_q <= setup;
      pslverr_q <= setup & ~mapped;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= irq_d;
    end
  end

  // One flop per status flag keeps the unused positions out of the register file
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cal_q <= STA_RST[CAL_BIT];
    end else begin
      cal_q <= cal_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vt_err_q <= STA_RST[VT_ERR_BIT];
    end else begin
      vt_err_q <= vt_err_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur_err_q <= STA_RST[CUR_ERR_BIT];
    end else begin
      cur_err_q <= cur_err_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cont_q <= STA_RST[CONT_BIT];
    end else begin
      cont_q <= cont_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp_q <= STA_RST[CMP_BIT];
    end else begin
      cmp_q <= cmp_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trdy_q <= STA_RST[TRDY_BIT];
    end else begin
      trdy_q <= trdy_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vrdy_q <= STA_RST[VRDY_BIT];
    end else begin
      vrdy_q <= vrdy_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      crdy_q <= STA_RST[CRDY_BIT];
    end else begin
      crdy_q <= crdy_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      msk_q <= MSK_RST;
    end else begin
      msk_q <= msk_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mde_q <= MDE_RST;
    end else begin
      mde_q <= mde_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flt_q <= FLT_RST;
    end else begin
      flt_q <= flt_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_q <= CTL_RST;
    end else begin
      ctl_q <= ctl_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      th_q <= TH_RST;
    end else begin
      th_q <= th_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q <= CFG_RST;
    end else begin
      cfg_q <= cfg_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur_dat_q <= DAT_RST;
    end else begin
      cur_dat_q <= cur_dat_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vt_dat_q <= DAT_RST;
    end else begin
      vt_dat_q <= vt_dat_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign conv_irq = irq_q;
  assign conv_mode = mde_q;
  assign conv_filter = flt_q;
  assign cur_ctrl = ctl_q;
  assign conv_config = cfg_q;

endmodule

/* File: asimr_regs_properties.sv */
`timescale 1ns/1ns
module asimr_regs_chk
  import asimr_pkg::*;
(
  input wire logic pclk, // Clock
  input wire logic presetn, // Reset
  input wire logic psel, // Select
  input wire logic penable, // Enable
  input wire logic pwrite, // Write
  input wire logic [31:0] paddr, // Address
  input wire logic [31:0] pwdata, // Wdata
  input wire logic [31:0] prdata, // Rdata
  input wire logic pready, // Ready
  input wire logic pslverr, // Error
  input wire asimr_evt_t cur_evt, // Cur event
  input wire asimr_evt_t vt_evt, // V/T event
  input wire logic cal_done, // Cal end
  input wire logic conv_irq, // Irq
  input wire logic [7:0] conv_mode // Mode
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire acc = psel && penable && pready;
  wire setup = psel && !penable;
  wire mde_wr = acc && pwrite && paddr == MDE_OFS;
  wire [7:0] wlo = pwdata[7:0];
  // Only conversion events, calibration ends and mask writes can newly raise the irq
  wire cause = cur_evt.done || vt_evt.done || cal_done || (acc && pwrite && paddr == MSK_OFS);
  chk_sta_spare: assert property (acc && !pwrite && paddr == STA_OFS |->
    (prdata & 32'hFFFF_4FC8) == 32'h0) else $error("spare status bits set");
  chk_mode_write: assert property (mde_wr |=> conv_mode == $past(wlo))
    else $error("mode write lost");
  chk_mode_hold: assert property (!mde_wr |=> $stable(conv_mode))
    else $error("mode changed unwritten");
  chk_irq_rise: assert property ($rose(conv_irq) |-> $past(cause, 2))
    else $error("irq rose without cause");
  chk_irq_fall: assert property ($fell(conv_irq) |-> $past(acc, 2))
    else $error("irq fell without access");
  chk_err_data: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error response malformed");
  chk_ready_once: assert property (setup |=> pready ##1 !pready)
    else $error("ready not one cycle");
  chk_ready_cause: assert property (pready |-> $past(setup))
    else $error("ready without setup");
endmodule
bind asimr_regs asimr_regs_chk u_chk (.*);

/* File: asimr_cpu.sv */
`timescale 1ns/1ns
module asimr_cpu (
  input wire logic pclk, // Clock
  output logic psel, // Select
  output logic penable, // Enable
  output logic pwrite, // Write
  output logic [31:0] paddr, // Address
  output logic [31:0] pwdata, // Wdata
  input wire logic pready // Ready
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
  end
  task automatic xfer(input logic w, input logic [31:0] a, d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    // Inverted idle values so stale lines never look valid
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule

/* File: testbench.sv */
`timescale 1ns/1ns
module testbench
  import asimr_pkg::*;
;
  logic pclk = 0, presetn = 0, cal_done = 0, core_pwr_down = 0;
  logic [7:0] conv_mode, conv_config;
  logic [15:0] conv_filter, cur_ctrl;
  logic qe[$];
  logic psel, penable, pwrite, pready, pslverr, conv_irq;
  logic [31:0] paddr, pwdata, prdata, q[$];
  asimr_evt_t cur_evt = '0, vt_evt = '0;
  int n_errors = 0, checks = 0, cyc = 0;
  logic [15:0] r;
  initial forever #2 pclk = ~pclk;
  asimr_cpu cpu (.*);
  asimr_regs dut (.*);
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [31:0] a, d);
    cpu.xfer(1'b1, a, d);
  endtask
  task automatic rd(input logic [31:0] a, e, input logic err = 1'b0);
    q.push_back(e);
    qe.push_back(err);
    cpu.xfer(1'b0, a, 32'h0);
  endtask
  task automatic ev(input logic v, input logic [3:0] f, input logic [15:0] d);
    @(posedge pclk);
    if (v) vt_evt <= {f, d};
    else cur_evt <= {f, d};
    @(posedge pclk);
    vt_evt <= '0;
    cur_evt <= '0;
  endtask
  task automatic cal();
    @(posedge pclk) cal_done <= 1'b1;
    @(posedge pclk) cal_done <= 1'b0;
  endtask
  task automatic report_and_stop();
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite && q.size() > 0) begin
      chk("rdata", prdata, q.pop_front());
      chk("pslverr", 32'(pslverr), 32'(qe.pop_front()));
    end
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      report_and_stop();
    end
  end
  initial begin
    void'($urandom(32'hE5B26AA2));
    r = 16'($urandom);
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rd(STA_OFS, 32'h0);
    rd(MSK_OFS, 32'h0);
    rd(MDE_OFS, 32'h0);
    wr(STA_OFS, 32'hFFFF);
    rd(STA_OFS, 32'h0);
    rd(32'hFFFF_05FC, 32'h0, 1'b1);
    wr(MDE_OFS, {r, r});
    rd(MDE_OFS, {24'h0, r[7:0]});
    chk("mode", 32'(conv_mode), {24'h0, r[7:0]});
    $display("test regs done");
    wr(CTL_OFS, 32'h8000);
    wr(CFG_OFS, 32'h7);
    wr(TH_OFS, 32'h100);
    cal();
    chk("ctrl", 32'(cur_ctrl), 32'h8000);
    chk("config", 32'(conv_config), 32'h7);
    rd(STA_OFS, 32'h8007);
    wr(FLT_OFS, {16'h0, r});
    rd(STA_OFS, 32'h7);
    chk("filter", 32'(conv_filter), {16'h0, r});
    rd(CUR_OFS, 32'h0);
    rd(STA_OFS, 32'h0);
    $display("test cal done");
    wr(MDE_OFS, 32'h20);
    ev(0, 4'b1100, r);
    rd(STA_OFS, 32'h1031);
    rd(CUR_OFS, {16'h0, POS_FS});
    ev(0, 4'b1000, 16'h5);
    ev(0, 4'b1010, 16'h5);
    rd(CUR_OFS, 32'h5);
    rd(STA_OFS, 32'h1010);
    ev(0, 4'b1000, 16'h5);
    rd(STA_OFS, 32'h31);
    wr(CFG_OFS, 32'h6);
    rd(STA_OFS, 32'h21);
    $display("test current done");
    ev(1, 4'b1011, 16'h0);
    rd(STA_OFS, 32'h2025);
    rd(VT_OFS, {16'h0, NEG_FS});
    rd(STA_OFS, 32'h2021);
    ev(1, 4'b1000, r);
    rd(STA_OFS, 32'h23);
    rd(CUR_OFS, 32'h5);
    rd(STA_OFS, 32'h0);
    rd(VT_OFS, {16'h0, r});
    $display("test vt done");
    wr(MDE_OFS, 32'h0);
    ev(0, 4'b1000, r);
    rd(STA_OFS, 32'h1);
    wr(MSK_OFS, 32'h1);
    repeat (2) @(posedge pclk);
    chk("irq", 32'(conv_irq), 32'h1);
    wr(MSK_OFS, 32'h20);
    cal();
    repeat (2) @(posedge pclk);
    chk("irq", 32'(conv_irq), 32'h0);
    rd(MSK_OFS, 32'h20);
    rd(STA_OFS, 32'h8007);
    $display("test irq done");
    core_pwr_down <= 1'b1;
    ev(0, 4'b1000, 16'h9);
    rd(CUR_OFS, 32'h9);
    core_pwr_down <= 1'b0;
    $display("test power down done");
    @(posedge pclk);
    report_and_stop();
  end
endmodule
